// ---- bmo_pkg.sv ----
package bmo_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int BMO_LANES = 7;
  localparam int BMO_SEL_W = 3;
  localparam int BMO_PIN_W = 7;
  localparam int BMO_SYNC = 3;
  localparam logic [BMO_SEL_W-1:0] BMO_SEL_RST = 3'h0;
  localparam logic [BMO_SEL_W-1:0] BMO_SEL_MAX = 3'h6;
  localparam logic [BMO_PIN_W-1:0] BMO_PIN_RST = 7'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic {
    BMO_TRIG_SCRIPT,
    BMO_TRIG_DECODER
  } bmo_trig_src_t;

  typedef struct packed {
    logic [1:0] script_mark;
    logic [1:0] decoder_event;
  } bmo_trig_in_t;

  typedef struct packed {
    logic [BMO_LANES-1:0] tx;
    logic [BMO_LANES-1:0] rx;
  } bmo_lane_pair_t;

endpackage

// ---- bmo_sync.sv ----
`timescale 1ns/1ns
module bmo_sync
  import bmo_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_sync_out;

  // stage one feeds only stage two, no other reader
  always_comb begin
    next_sync_out = sync_out;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_sync_out[i] = s3[i];
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ---- bmo_monitor.sv ----
`timescale 1ns/1ns
// Contract
// - Buffered clock output copies the captured bus clock without loading the bus.
// - Buffered data output copies exactly one of seven lanes, chosen by select.
// - Lane select changeable by script command or host application.
// - Mismatch output set on each bit slot strobe to whether transmitted and captured bus values differ, held between strobes.
// - Two event marker outputs, each drivable by a script command.
// - Markers alternatively driven by the internal event decoder, filter host-set.
// - After reset multi-purpose pins are inputs, captured once every frame.
// - With audio option, multi-purpose pins may become audio lanes and clocks.
// - General inputs sampled at the start of each frame for the trace.
module bmo_monitor
  import bmo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_clk_pin,
  input wire bmo_lane_pair_t lanes,
  input wire logic bit_slot_strobe,
  input wire logic frame_start,
  input wire logic script_sel_we,
  input wire logic [BMO_SEL_W-1:0] script_sel,
  input wire logic host_sel_we,
  input wire logic [BMO_SEL_W-1:0] host_sel,
  input wire bmo_trig_src_t trig_src,
  input wire bmo_trig_in_t trig_in,
  input wire logic audio_option,
  input wire logic audio_mode_req,
  input wire logic [BMO_PIN_W-1:0] audio_out_data,
  input wire logic [BMO_PIN_W-1:0] general_input_pin_i,
  output logic [BMO_PIN_W-1:0] general_input_pin_o,
  output logic [BMO_PIN_W-1:0] general_input_pin_oe_n,
  output logic buf_clk,
  output logic buf_data,
  output logic data_diff,
  output logic [1:0] trig_out,
  output logic [BMO_PIN_W-1:0] pin_sample,
  output logic pin_sample_valid,
  output logic audio_mode
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [BMO_PIN_W-1:0] pin_sync;
  logic clk_sync;

  // the general inputs come straight off the header, at any phase
  bmo_sync #(.WIDTH(BMO_PIN_W)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(general_input_pin_i),
    .sync_out(pin_sync)
  );

  // the bus clock is a pin as well; the mirror trades a few cycles of lag
  // for a probe output that never shows a metastable level
  bmo_sync #(.WIDTH(1)) u_clk_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(bus_clk_pin),
    .sync_out(clk_sync)
  );

  // ----------------------------------------------------------------
  // lane select, script or host
  // ----------------------------------------------------------------
  logic [BMO_SEL_W-1:0] lane_sel;
  logic [BMO_SEL_W-1:0] next_lane_sel;

  // an out-of-range lane index keeps the last valid one
  function automatic logic sel_ok(input logic [BMO_SEL_W-1:0] s);
    return s <= BMO_SEL_MAX;
  endfunction

  // script wins a same-cycle collision: it runs the sequence in progress
  always_comb begin
    next_lane_sel = lane_sel;
    if (script_sel_we && sel_ok(script_sel)) begin
      next_lane_sel = script_sel;
    end else if (host_sel_we && sel_ok(host_sel)) begin
      next_lane_sel = host_sel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lane_sel <= BMO_SEL_RST;
    end else begin
      lane_sel <= next_lane_sel;
    end
  end

  // ----------------------------------------------------------------
  // clock mirror
  // ----------------------------------------------------------------
  logic next_buf_clk;

  // limitation: a bus clock level shorter than two ref_clk cycles is
  // filtered out, so the mirror is faithful up to a quarter of ref_clk
  always_comb begin
    next_buf_clk = clk_sync;
  end

  // registers only; the probe never loads the bus itself
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buf_clk <= 1'b0;
    end else begin
      buf_clk <= next_buf_clk;
    end
  end

  // ----------------------------------------------------------------
  // data lane mirror
  // ----------------------------------------------------------------
  logic next_buf_data;

  // lane_sel never leaves the legal range, so the index is always defined
  always_comb begin
    next_buf_data = lanes.rx[lane_sel];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buf_data <= 1'b0;
    end else begin
      buf_data <= next_buf_data;
    end
  end

  // ----------------------------------------------------------------
  // transmit / capture mismatch
  // ----------------------------------------------------------------
  logic next_data_diff;

  // compared only on the slot strobe: between slots tx and rx may belong
  // to different bits and would flag a clash that is not there
  always_comb begin
    next_data_diff = data_diff;
    if (bit_slot_strobe) begin
      next_data_diff = |(lanes.tx ^ lanes.rx);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_diff <= 1'b0;
    end else begin
      data_diff <= next_data_diff;
    end
  end

  // ----------------------------------------------------------------
  // event markers
  // ----------------------------------------------------------------
  logic [1:0] next_trig_out;

  // one source at a time; mixing both would hide which one fired
  always_comb begin
    unique case (trig_src)
      BMO_TRIG_SCRIPT: next_trig_out = trig_in.script_mark;
      BMO_TRIG_DECODER: next_trig_out = trig_in.decoder_event;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trig_out <= 2'h0;
    end else begin
      trig_out <= next_trig_out;
    end
  end

  // ----------------------------------------------------------------
  // multi-purpose pin direction
  // ----------------------------------------------------------------
  logic next_audio_mode;
  logic [BMO_PIN_W-1:0] next_pin_o;
  logic [BMO_PIN_W-1:0] next_pin_oe_n;

  // audio mode only exists with the option fitted; otherwise pins stay inputs
  always_comb begin
    next_audio_mode = audio_option && audio_mode_req;
    next_pin_o = BMO_PIN_RST;
    next_pin_oe_n = {BMO_PIN_W{1'b1}};
    if (next_audio_mode) begin
      next_pin_o = audio_out_data;
      next_pin_oe_n = {BMO_PIN_W{1'b0}};
    end
  end

  // direction and data switch on the same edge, so no pin drives stale data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      audio_mode <= 1'b0;
      general_input_pin_o <= BMO_PIN_RST;
      general_input_pin_oe_n <= {BMO_PIN_W{1'b1}};
    end else begin
      audio_mode <= next_audio_mode;
      general_input_pin_o <= next_pin_o;
      general_input_pin_oe_n <= next_pin_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // per-frame capture of the general inputs
  // ----------------------------------------------------------------
  logic [BMO_PIN_W-1:0] next_pin_sample;
  logic next_pin_sample_valid;

  // the sample stands until the next frame, so the trace writer may be late
  always_comb begin
    next_pin_sample = pin_sample;
    next_pin_sample_valid = 1'b0;
    if (frame_start) begin
      next_pin_sample = pin_sync;
      next_pin_sample_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_sample <= BMO_PIN_RST;
      pin_sample_valid <= 1'b0;
    end else begin
      pin_sample <= next_pin_sample;
      pin_sample_valid <= next_pin_sample_valid;
    end
  end

endmodule

// ---- bmo_probe.sv ----
`timescale 1ns/1ns
// passive scope channel on the buffered clock: it only counts rising edges
module bmo_probe (
  input wire logic ref_clk,
  input wire logic buf_clk,
  output logic [6:0] edges
);
  logic last = 1'b0;
  initial edges = 7'h00;
  // sampled on ref_clk, so bus clock must stay well below half that rate
  always @(posedge ref_clk) begin
    if (buf_clk && !last) edges <= edges + 7'h01;
    last <= buf_clk;
  end
endmodule

// ---- bmo_mon_asserts.sv ----
`timescale 1ns/1ns
module bmo_mon_asserts
  import bmo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_clk_pin,
  input wire bmo_lane_pair_t lanes,
  input wire logic bit_slot_strobe,
  input wire logic frame_start,
  input wire bmo_trig_src_t trig_src,
  input wire bmo_trig_in_t trig_in,
  input wire logic audio_option,
  input wire logic [BMO_PIN_W-1:0] general_input_pin_oe_n,
  input wire logic buf_clk,
  input wire logic data_diff,
  input wire logic [1:0] trig_out,
  input wire logic pin_sample_valid,
  input wire logic audio_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // every check but a_pins_input is gated by an earlier reset level (a_clk_copy five cycles back), outputs but general_input_pin_oe_n (all ones) are zero after it
  // the clock mirror filters through three stages: a level seen on two
  // neighbouring samples reaches buf_clk five edges later
  a_clk_copy: assert property ($past(rst_n, 5) &&
    $past(bus_clk_pin, 4) == $past(bus_clk_pin, 5) |-> buf_clk == $past(bus_clk_pin, 5))
    else $error("buf_clk not a copy");
  a_diff_set: assert property ($past(rst_n) && $past(bit_slot_strobe) |->
    data_diff == $past(|(lanes.tx ^ lanes.rx))) else $error("data_diff wrong");
  a_diff_hold: assert property ($past(rst_n) && !$past(bit_slot_strobe) |->
    $stable(data_diff)) else $error("data_diff moved off slot");
  a_trig_script: assert property ($past(rst_n) && $past(trig_src) == BMO_TRIG_SCRIPT |->
    trig_out == $past(trig_in.script_mark)) else $error("script mark lost");
  a_trig_decode: assert property ($past(rst_n) && $past(trig_src) == BMO_TRIG_DECODER |->
    trig_out == $past(trig_in.decoder_event)) else $error("decoder event lost");
  a_pin_frame: assert property ($past(rst_n) |->
    pin_sample_valid == $past(frame_start)) else $error("pin sample not per frame");
  a_pins_input: assert property (!audio_mode |-> general_input_pin_oe_n == 7'h7f)
    else $error("pins driven outside audio mode");
  a_audio_gate: assert property ($past(rst_n) && !$past(audio_option) |-> !audio_mode)
    else $error("audio mode without option");
endmodule
bind bmo_monitor bmo_mon_asserts chk (.ref_clk, .rst_n, .bus_clk_pin, .lanes, .bit_slot_strobe,
  .frame_start, .trig_src, .trig_in, .audio_option, .general_input_pin_oe_n, .buf_clk,
  .data_diff, .trig_out, .pin_sample_valid, .audio_mode);

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import bmo_pkg::*;
  logic ref_clk = 0, rst_n = 0, bus_clk_pin = 0, bit_slot_strobe = 0, frame_start = 0;
  logic script_sel_we = 0, host_sel_we = 0, audio_option = 0, audio_mode_req = 0;
  logic [2:0] script_sel = 3'h0, host_sel = 3'h0;
  bmo_lane_pair_t lanes = 14'h0000;
  bmo_trig_src_t trig_src = BMO_TRIG_SCRIPT;
  bmo_trig_in_t trig_in = 4'h0;
  logic [6:0] audio_out_data = 7'h00, general_input_pin_i = 7'h00, edges;
  logic [6:0] general_input_pin_o, general_input_pin_oe_n, pin_sample;
  logic buf_clk, buf_data, data_diff, pin_sample_valid, audio_mode;
  logic [1:0] trig_out;
  int err_total = 0, total_checks = 0, cyc = 0;
  bmo_monitor dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_clk_pin(bus_clk_pin), .lanes(lanes),
    .bit_slot_strobe(bit_slot_strobe), .frame_start(frame_start),
    .script_sel_we(script_sel_we), .script_sel(script_sel),
    .host_sel_we(host_sel_we), .host_sel(host_sel),
    .trig_src(trig_src), .trig_in(trig_in),
    .audio_option(audio_option), .audio_mode_req(audio_mode_req),
    .audio_out_data(audio_out_data), .general_input_pin_i(general_input_pin_i),
    .general_input_pin_o(general_input_pin_o),
    .general_input_pin_oe_n(general_input_pin_oe_n),
    .buf_clk(buf_clk), .buf_data(buf_data), .data_diff(data_diff), .trig_out(trig_out),
    .pin_sample(pin_sample), .pin_sample_valid(pin_sample_valid), .audio_mode(audio_mode)
  );
  bmo_probe scope (.ref_clk, .buf_clk, .edges);
  always #5 ref_clk = ~ref_clk;
  // hang guard: the whole run needs under a hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      $display("ERROR run_cycles expected below %0d seen %0d", 3000, cyc);
      err_total++;
      test_done;
    end
  end
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input string nm, input logic [6:0] exp, input logic [6:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  // select pulse is one cycle, buf_data follows a cycle later
  task sel(input logic [2:0] sv, input logic [2:0] hv, input logic [1:0] we);
    {script_sel, host_sel, script_sel_we, host_sel_we} = {sv, hv, we};
    step(1);
    {script_sel_we, host_sel_we} = 2'b00;
    step(1);
  endtask
  task t_clk;
    repeat (10) begin
      bus_clk_pin = ~bus_clk_pin;
      step(2);
    end
    // the mirror lags the pin by five cycles, the scope by one more
    step(6);
    chk("scope edges", 7'h05, edges);
  endtask
  task t_lane;
    for (int k = 0; k < 7; k++) begin
      lanes.rx = 7'h01 << k;
      sel(3'(k), 3'(k), {k[0], !k[0]});
      chk("buf_data", 7'h01, 7'(buf_data));
    end
    sel(3'h0, 3'h7, 2'b01);
    chk("sel 7 refused", 7'h01, 7'(buf_data));
    lanes.rx = 7'h04;
    sel(3'h2, 3'h5, 2'b11);
    chk("script wins", 7'h01, 7'(buf_data));
  endtask
  task t_diff;
    lanes = {7'h00, 7'h08};
    bit_slot_strobe = 1;
    step(1);
    bit_slot_strobe = 0;
    chk("diff set", 7'h01, 7'(data_diff));
    lanes.rx = 7'h00;
    step(2);
    chk("diff held", 7'h01, 7'(data_diff));
    bit_slot_strobe = 1;
    step(1);
    bit_slot_strobe = 0;
    chk("diff clear", 7'h00, 7'(data_diff));
  endtask
  task t_trig;
    trig_in = 4'h9;
    for (int k = 0; k < 2; k++) begin
      trig_src = bmo_trig_src_t'(k);
      step(1);
      chk("trig_out", k ? 7'h01 : 7'h02, 7'(trig_out));
    end
  endtask
  task t_pins;
    chk("oe_n reset", 7'h7f, general_input_pin_oe_n);
    general_input_pin_i = 7'h5a;
    step(6);
    frame_start = 1;
    step(1);
    frame_start = 0;
    chk("pin_sample", 7'h5a, pin_sample);
    chk("valid", 7'h01, 7'(pin_sample_valid));
    step(1);
    chk("valid end", 7'h00, 7'(pin_sample_valid));
  endtask
  task t_audio;
    audio_mode_req = 1;
    audio_out_data = 7'h33;
    step(2);
    chk("no option", 7'h00, 7'(audio_mode));
    audio_option = 1;
    step(3);
    chk("audio oe_n", 7'h00, general_input_pin_oe_n);
    chk("audio data", 7'h33, general_input_pin_o);
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    step(20);
    rst_n = 1;
    t_pins;
    t_clk;
    t_lane;
    t_diff;
    t_trig;
    t_audio;
    test_done;
  end
endmodule
